// *** src/ucore_ops_pkg.sv ***
package ucore_ops_pkg;
    // Instruction layout (16-bit words)
    localparam int INSTR_W = 16;
    localparam int DATA_W = 16;
    localparam int REG_SEL_W = 3;
    localparam int IMM_W = 4;
    localparam int ROWS = 5;
    localparam int PC_W = 10;

    // Subtract-immediate: bits 15:10 fixed, res 9:7, imm 6:3, src 2:0
    localparam logic [5:0] SUBI_OP = 6'h07;
    localparam int SUBI_OP_LSB = 10;
    localparam int SUBI_RES_LSB = 7;
    localparam int SUBI_IMM_LSB = 3;
    localparam int SRC_LSB = 0;

    // Single-operand instructions: bits 15:4 fixed, bit 3 option on DEC, zero on SWAP and ENC
    localparam int SINGLE_LSB = 4;
    localparam logic [11:0] SWAP_OP = 12'h0356;
    localparam logic [11:0] ENC_OP = 12'h0373;
    localparam logic [11:0] DEC_OP = 12'h0372;
    localparam int DEC_RST_BIT = 3;

    // Wait: bits 15:5 fixed, mask 4:0
    localparam int WAIT_LSB = 5;
    localparam logic [10:0] WAIT_OP = 11'h01A8;

    // Backdoor write: whole word fixed
    localparam logic [15:0] BDW_OP = 16'h3541;

    // Condition register bit positions
    localparam int CR_ZERO = 0;
    localparam int CR_NEG = 1;
    localparam int CR_UUND = 2;
    localparam int CR_UOVF = 3;
    localparam int CR_SUND = 4;
    localparam int CR_SOVF = 5;
    localparam int CR_CSIGN = 6;
    localparam int CR_W = 7;

    // Backdoor write latency in core cycles
    localparam int BDW_CYCLES = 2;

    localparam logic [15:0] MSB_MASK = 16'h8000;
    localparam logic [15:0] LOW15_MASK = 16'h7FFF;
endpackage : ucore_ops_pkg

// *** src/ucore_ops.sv ***
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ucore_ops #(
    parameter int NREGS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [9:0] pc_in,
    // Wait table, loaded by the configuration instructions elsewhere
    input wire logic [4:0] wait_cond,
    input wire logic [49:0] wait_dest,
    // Backdoor source registers and their write strobe from the core
    input wire logic [15:0] bd_addr,
    input wire logic [15:0] bd_data,
    input wire logic bd_regs_written,
    // Register file and program counter
    output logic [15:0] reg_out [8],
    output logic [9:0] program_counter,
    output logic pc_hold,
    output logic [6:0] cond_reg,
    // Backdoor write request
    output logic bd_wr,
    output logic [15:0] bd_wr_addr,
    output logic [15:0] bd_wr_data
);
    localparam int DW = ucore_ops_pkg::DATA_W;
    localparam int PW = ucore_ops_pkg::PC_W;

    if (NREGS != 8) begin : g_nregs_check
        $error("NREGS must be 8 to match the 3-bit register select");
    end

    typedef struct packed {
        logic [8*DW-1:0] regs;
        logic [ucore_ops_pkg::CR_W-1:0] cr;
        logic [PW-1:0] pc;
        logic waiting;
        logic [ucore_ops_pkg::ROWS-1:0] mask;
        logic [1:0] bd_cnt;
        logic bd_bad;
        logic [DW-1:0] bd_a;
        logic [DW-1:0] bd_d;
        logic bd_wr;
        logic [DW-1:0] bd_wa;
        logic [DW-1:0] bd_wd;
    } state_s;

    state_s q, d;

    // =========================================================
    // Decode
    // =========================================================
    logic [2:0] src_sel, res_sel;
    logic [3:0] imm;
    logic is_subi, is_swap, is_enc, is_dec, is_wait, is_bdw;
    logic [DW-1:0] src_val, res_val;
    logic [DW:0] diff;
    logic [DW-1:0] neg15;
    logic [ucore_ops_pkg::ROWS-1:0] hit;
    logic [PW-1:0] jump;

    always_comb begin
        src_sel = instr[ucore_ops_pkg::SRC_LSB +: 3];
        res_sel = instr[ucore_ops_pkg::SUBI_RES_LSB +: 3];
        imm = instr[ucore_ops_pkg::SUBI_IMM_LSB +: ucore_ops_pkg::IMM_W];
        // Fixed opcode patterns
        is_subi = instr_valid && instr[15:ucore_ops_pkg::SUBI_OP_LSB]
            == ucore_ops_pkg::SUBI_OP;
        is_swap = instr_valid && instr[15:ucore_ops_pkg::SINGLE_LSB]
            == ucore_ops_pkg::SWAP_OP && instr[3] == 1'b0;
        is_enc = instr_valid && instr[15:ucore_ops_pkg::SINGLE_LSB]
            == ucore_ops_pkg::ENC_OP && instr[3] == 1'b0;
        is_dec = instr_valid && instr[15:ucore_ops_pkg::SINGLE_LSB]
            == ucore_ops_pkg::DEC_OP;
        is_wait = instr_valid && instr[15:ucore_ops_pkg::WAIT_LSB]
            == ucore_ops_pkg::WAIT_OP;
        is_bdw = instr_valid && instr == ucore_ops_pkg::BDW_OP;
    end

    // Row select: lowest numbered satisfied row wins
    always_comb begin
        hit = wait_cond & q.mask;
        jump = q.pc;
        for (int r = ucore_ops_pkg::ROWS - 1; r >= 0; r--) begin
            if (hit[r]) begin
                jump = wait_dest[r*PW +: PW];
            end
        end
    end

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        d = q;
        d.bd_wr = 1'b0;
        src_val = q.regs[src_sel*DW +: DW];
        diff = {1'b0, src_val} - {13'h0000, imm};
        neg15 = DW'(-{1'b0, src_val[DW-2:0]}) & ucore_ops_pkg::LOW15_MASK;
        res_val = src_val;
        if (q.waiting) begin
            // Empty mask never hits, so the stall never ends
            if (|hit) begin
                d.waiting = 1'b0;
                d.pc = jump;
            end
        end else if (instr_valid) begin
            d.pc = pc_in;
            if (is_subi) begin
                res_val = diff[DW-1:0];
                d.regs[res_sel*DW +: DW] = res_val;
                d.cr[ucore_ops_pkg::CR_ZERO] = res_val == 16'h0000;
                d.cr[ucore_ops_pkg::CR_NEG] = res_val[DW-1];
                d.cr[ucore_ops_pkg::CR_UUND] = diff[DW];
                // Small positive immediate cannot overflow unsigned
                d.cr[ucore_ops_pkg::CR_UOVF] = 1'b0;
                d.cr[ucore_ops_pkg::CR_SUND] = src_val[DW-1] &
                    ~res_val[DW-1];
                d.cr[ucore_ops_pkg::CR_SOVF] = 1'b0;
            end else if (is_swap) begin
                d.regs[src_sel*DW +: DW] = {src_val[7:0],
                    src_val[15:8]};
            end else if (is_enc) begin
                if (!q.cr[ucore_ops_pkg::CR_CSIGN]) begin
                    d.regs[src_sel*DW +: DW] = src_val &
                        ucore_ops_pkg::LOW15_MASK;
                end else begin
                    d.regs[src_sel*DW +: DW] = neg15 |
                        ucore_ops_pkg::MSB_MASK;
                end
            end else if (is_dec) begin
                if (src_val[DW-1]) begin
                    d.regs[src_sel*DW +: DW] = neg15;
                end // else unchanged
                if (instr[ucore_ops_pkg::DEC_RST_BIT]) begin
                    d.cr[ucore_ops_pkg::CR_CSIGN] = src_val[DW-1];
                end else begin
                    d.cr[ucore_ops_pkg::CR_CSIGN] =
                        q.cr[ucore_ops_pkg::CR_CSIGN] ^ src_val[DW-1];
                end
            end else if (is_wait) begin
                d.waiting = 1'b1;
                d.pc = q.pc;
                d.mask = instr[ucore_ops_pkg::ROWS-1:0];
            end
        end
        // Backdoor write pipeline
        if (q.bd_cnt != 2'd0) begin
            if (bd_regs_written) begin
                d.bd_bad = 1'b1;
            end
            d.bd_cnt = q.bd_cnt - 2'd1;
            if (q.bd_cnt == 2'd1) begin
                d.bd_wr = 1'b1;
                d.bd_wa = q.bd_bad || bd_regs_written ? bd_addr : q.bd_a;
                d.bd_wd = q.bd_bad || bd_regs_written ? ~bd_data : q.bd_d;
            end
        end
        if (is_bdw && !q.waiting) begin
            // The issue edge itself counts as the first of the cycles
            d.bd_cnt = 2'(ucore_ops_pkg::BDW_CYCLES - 1);
            d.bd_bad = 1'b0;
            d.bd_a = bd_addr;
            d.bd_d = bd_data;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    for (genvar g = 0; g < 8; g++) begin : g_regs
        assign reg_out[g] = q.regs[g*DW +: DW];
    end
    assign program_counter = q.pc;
    assign pc_hold = q.waiting;
    assign cond_reg = q.cr;
    assign bd_wr = q.bd_wr;
    assign bd_wr_addr = q.bd_wa;
    assign bd_wr_data = q.bd_wd;

    // =========================================================
    // Checks
    // =========================================================
    // All checks share the core clock, so one default serves them all
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    AST_BDW_TWO: assert property (
        (is_bdw && !q.waiting) |-> ##2 bd_wr)
        else $error("backdoor write not done two cycles after issue");

    AST_BDW_FAIL: assert property (
        (is_bdw && !q.waiting ##1 bd_regs_written) |-> ##1 (bd_wr &&
        bd_wr_addr == $past(bd_addr) && bd_wr_data == ~$past(bd_data)))
        else $error("corrupted backdoor write not flagged");

    AST_BDW_DATA: assert property (
        (is_bdw && !q.waiting ##1 !bd_regs_written) |-> ##1 (bd_wr &&
        bd_wr_addr == $past(bd_addr, 2) && bd_wr_data == $past(bd_data, 2)))
        else $error("backdoor write carried wrong address or data");

    AST_WAIT_HOLD: assert property (
        (q.waiting && !(|hit)) |=> $stable(program_counter) && pc_hold)
        else $error("program counter moved during wait");

    AST_WAIT_JUMP: assert property (
        (q.waiting && |hit) |=> !pc_hold && program_counter == $past(jump))
        else $error("wait did not jump to destination");

    AST_WAIT_REFUSE: assert property (
        q.waiting |=> $stable(q.regs) && $stable(cond_reg))
        else $error("instruction executed during wait");

    AST_WAIT_ROW1: assert property (
        (q.waiting && hit[0]) |=>
        program_counter == $past(wait_dest[PW-1:0]))
        else $error("row one destination not taken");

    AST_WAIT_ENTER: assert property (
        (is_wait && !q.waiting) |=>
        pc_hold && q.mask == $past(instr[ucore_ops_pkg::ROWS-1:0]))
        else $error("wait mask not captured");

    AST_ZERO_MASK: assert property (
        (q.waiting && q.mask == 5'h00) |=> pc_hold)
        else $error("zero mask wait released");

    AST_SUBI: assert property (
        (is_subi && !q.waiting) |=> reg_out[$past(res_sel)] ==
        16'($past(src_val) - {12'h000, $past(imm)}))
        else $error("subtract-immediate result wrong");

    AST_SUBI_Z: assert property (
        (is_subi && !q.waiting) |=> cond_reg[ucore_ops_pkg::CR_ZERO] ==
        ($past(src_val) == {12'h000, $past(imm)}))
        else $error("zero flag wrong after subtract-immediate");

    AST_SUBI_UU: assert property (
        (is_subi && !q.waiting) |=> cond_reg[ucore_ops_pkg::CR_UUND] ==
        ($past(src_val) < 16'($past(imm))))
        else $error("unsigned underflow flag wrong");

    AST_SUBI_N: assert property (
        (is_subi && !q.waiting) |=> cond_reg[ucore_ops_pkg::CR_NEG] ==
        reg_out[$past(res_sel)][DW-1])
        else $error("negative flag wrong");

    AST_SWAP: assert property (
        (is_swap && !q.waiting) |=> reg_out[$past(src_sel)] ==
        {$past(src_val[7:0]), $past(src_val[15:8])})
        else $error("swap result wrong");

    AST_DEC_SIGN: assert property (
        (is_dec && !q.waiting && instr[3]) |=>
        cond_reg[ucore_ops_pkg::CR_CSIGN] == $past(src_val[15]))
        else $error("conversion sign not overwritten");

    AST_DEC_XOR: assert property (
        (is_dec && !q.waiting && !instr[ucore_ops_pkg::DEC_RST_BIT]) |=>
        cond_reg[ucore_ops_pkg::CR_CSIGN] ==
        ($past(q.cr[ucore_ops_pkg::CR_CSIGN]) ^ $past(src_val[DW-1])))
        else $error("conversion sign not toggled");

    AST_DEC_POS: assert property (
        (is_dec && !q.waiting && !src_val[DW-1]) |=>
        reg_out[$past(src_sel)] == $past(src_val))
        else $error("decode changed a positive operand");

    AST_DEC_NEG: assert property (
        (is_dec && !q.waiting && src_val[DW-1]) |=>
        reg_out[$past(src_sel)] == {1'b0, 15'(-$past(src_val[DW-2:0]))})
        else $error("decode of a negative operand wrong");

    AST_ENC_POS: assert property (
        (is_enc && !q.waiting && !q.cr[ucore_ops_pkg::CR_CSIGN]) |=>
        reg_out[$past(src_sel)] == ($past(src_val) & 16'h7FFF))
        else $error("encode with clear sign wrong");

    AST_ENC_NEG: assert property (
        (is_enc && !q.waiting && q.cr[ucore_ops_pkg::CR_CSIGN]) |=>
        reg_out[$past(src_sel)] == {1'b1, 15'(-$past(src_val[DW-2:0]))})
        else $error("encode with set sign wrong");
endmodule : ucore_ops

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ====================================================
    // Design ports
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [9:0] pc_in = 10'h000;
    logic [4:0] wait_cond = 5'h00;
    logic [49:0] wait_dest = {10'h105, 10'h104, 10'h103, 10'h102, 10'h101};
    logic [15:0] bd_addr = 16'h0000;
    logic [15:0] bd_data = 16'h0000;
    logic bd_regs_written = 1'b0;
    logic [15:0] regs [8];
    logic [9:0] pc;
    logic pc_hold;
    logic [6:0] cond_reg;
    logic bd_wr;
    logic [15:0] bd_wr_addr;
    logic [15:0] bd_wr_data;
    int n_fail = 0;
    int samples_checked = 0;

    always #12.5 clock = ~clock;

    ucore_ops u_ucore_ops (.clock(clock), .nrst(nrst),
        .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
        .wait_cond(wait_cond), .wait_dest(wait_dest), .bd_addr(bd_addr),
        .bd_data(bd_data), .bd_regs_written(bd_regs_written),
        .reg_out(regs), .program_counter(pc), .pc_hold(pc_hold),
        .cond_reg(cond_reg), .bd_wr(bd_wr), .bd_wr_addr(bd_wr_addr),
        .bd_wr_data(bd_wr_data));

    // ====================================================
    // Access tasks
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [15:0] subi(input int r, input int i, input int s);
        return {ucore_ops_pkg::SUBI_OP, r[2:0], i[3:0], s[2:0]};
    endfunction : subi

    function automatic logic [15:0] one(input logic [11:0] op, input logic o,
                                        input int s);
        return {op, o, s[2:0]};
    endfunction : one

    task automatic issue(input logic [15:0] word, input logic [9:0] p);
        @(posedge clock);
        instr <= word;
        instr_valid <= 1'b1;
        pc_in <= p;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask : issue

    // Rows outside the mask are raised first, so only the mask can release
    task automatic run_wait(input logic [4:0] mask, input logic [9:0] dest);
        int k;
        issue({ucore_ops_pkg::WAIT_OP, mask}, 10'h3FF);
        check("hold", 16'h0001, {15'h0, pc_hold});
        @(posedge clock);
        wait_cond <= ~mask;
        issue(subi(5, 1, 0), 10'h000);
        repeat (3) @(posedge clock);
        #1;
        check("masked hold", 16'h0001, {15'h0, pc_hold});
        check("refused", 16'h0000, regs[5]);
        if (mask == 5'h00) return;
        @(posedge clock);
        wait_cond <= 5'h1F;
        k = 0;
        while (pc_hold !== 1'b0 && k < 4) begin
            @(posedge clock);
            #1;
            k++;
        end
        check("wait dest", {6'h0, dest}, {6'h0, pc});
        check("released", 16'h0000, {15'h0, pc_hold});
        @(posedge clock);
        wait_cond <= 5'h00;
    endtask : run_wait

    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // ====================================================
    // Tests
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        issue(subi(1, 5, 0), 10'h011);
        check("r1", 16'hFFFB, regs[1]);
        check("flags", 16'h0006, {9'h0, cond_reg});
        check("pc", 16'h0011, {6'h0, pc});
        issue(subi(2, 0, 0), 10'h012);
        check("zero", 16'h0001, {9'h0, cond_reg});
        issue(subi(3, 15, 1), 10'h013);
        check("r3", 16'hFFEC, regs[3]);
        check("neg", 16'h0002, {9'h0, cond_reg});
        issue(one(ucore_ops_pkg::SWAP_OP, 1'b0, 3), 10'h014);
        check("swap", 16'hECFF, regs[3]);
        issue(one(ucore_ops_pkg::DEC_OP, 1'b1, 1), 10'h015);
        check("dec neg", 16'h0005, regs[1]);
        check("sign", 16'h0001, {15'h0, cond_reg[6]});
        issue(one(ucore_ops_pkg::ENC_OP, 1'b0, 1), 10'h016);
        check("enc r1", 16'hFFFB, regs[1]);
        issue(one(ucore_ops_pkg::ENC_OP, 1'b0, 2), 10'h017);
        check("enc r2", 16'h8000, regs[2]);
        issue(subi(4, 1, 2), 10'h018);
        check("r4", 16'h7FFF, regs[4]);
        check("sund", 16'h0010, {10'h0, cond_reg[5:0]});
        issue(one(ucore_ops_pkg::DEC_OP, 1'b0, 4), 10'h019);
        check("dec pos", 16'h7FFF, regs[4]);
        check("xor sign", 16'h0001, {15'h0, cond_reg[6]});
        issue(one(ucore_ops_pkg::DEC_OP, 1'b0, 2), 10'h01A);
        check("dec min", 16'h0000, regs[2]);
        check("xor sign", 16'h0000, {15'h0, cond_reg[6]});
        issue(one(ucore_ops_pkg::ENC_OP, 1'b0, 3), 10'h01B);
        check("enc pos", 16'h6CFF, regs[3]);
        issue(16'hFFFF, 10'h01C);
        check("undecoded pc", 16'h001C, {6'h0, pc});
        check("undecoded r3", 16'h6CFF, regs[3]);
        run_wait(5'b10100, 10'h103);
        for (int r = 0; r < 5; r++) begin
            run_wait(5'h01 << r, 10'h101 + 10'(r));
        end
        run_wait(5'h00, 10'h000);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        bd_addr <= 16'h0123;
        bd_data <= 16'hA5C3;
        #1;
        check("reset hold", 16'h0000, {15'h0, pc_hold});
        issue(ucore_ops_pkg::BDW_OP, 10'h030);
        check("bd early", 16'h0000, {15'h0, bd_wr});
        @(posedge clock);
        #1;
        check("bd pulse", 16'h0001, {15'h0, bd_wr});
        check("bd addr", 16'h0123, bd_wr_addr);
        check("bd data", 16'hA5C3, bd_wr_data);
        @(posedge clock);
        instr <= ucore_ops_pkg::BDW_OP;
        instr_valid <= 1'b1;
        #1;
        check("bd one cycle", 16'h0000, {15'h0, bd_wr});
        @(posedge clock);
        instr_valid <= 1'b0;
        bd_regs_written <= 1'b1;
        bd_addr <= 16'h0456;
        bd_data <= 16'h1234;
        @(posedge clock);
        bd_regs_written <= 1'b0;
        #1;
        check("bad pulse", 16'h0001, {15'h0, bd_wr});
        check("bad addr", 16'h0456, bd_wr_addr);
        check("bad data", 16'hEDCB, bd_wr_data);
        end_of_test();
    end

    initial begin
        #(25 * 4000);
        n_fail++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule : tb
